// file: design/bwm_lane_decode.sv
// lane write select decode for the 36-bit write path, with package
`timescale 1ns/10ps
package bwm_pkg;
  localparam int LANE_W  = 9;
  localparam int LANES   = 4;
  localparam int DATA_W  = 36;
  localparam int FIFO_DEPTH = 32;
  localparam logic [LANES-1:0] LANES_NONE = 4'h0;
  localparam logic [LANES-1:0] LANES_ALL  = 4'hf;
  localparam logic             PHASE_TRUE = 1'b0;
  localparam logic             PHASE_COMP = 1'b1;

  typedef struct packed {
    logic              phase;
    logic [LANES-1:0]  lane_we;
    logic [DATA_W-1:0] data;
  } bwm_beat_t;

  // values after reset
  localparam logic      STAGE_VALID_RST = 1'b0;
  localparam bwm_beat_t STAGE_RST       = '0;

  // low select enables its lane
  function automatic logic [LANES-1:0] lane_enables(input logic [LANES-1:0] sel_n);
    lane_enables = ~sel_n;
  endfunction

  // expands lane enables to a bit mask; lane n spans 9n+8 down to 9n
  function automatic logic [DATA_W-1:0] lane_mask(input logic [LANES-1:0] we);
    logic [DATA_W-1:0] m;
    m = '0;
    for (int n = 0; n < LANES; n++) begin
      m[n*LANE_W +: LANE_W] = {LANE_W{we[n]}};
    end
    lane_mask = m;
  endfunction
endpackage

module bwm_lane_decode
  import bwm_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              reset_n,
  // write beats from the controller side
  input  wire logic              beat_valid,
  input  wire logic              beat_phase,
  input  wire logic [DATA_W-1:0] beat_data,
  input  wire logic [LANES-1:0]  lane_write_select_n,
  output logic                   beat_ready,
  // masked writes toward the core
  output logic                   core_wr_valid,
  input  wire logic              core_wr_ready,
  output logic                   core_wr_phase,
  output logic      [LANES-1:0]  core_lane_we,
  output logic      [DATA_W-1:0] core_wr_data
);
  bwm_beat_t        stage_q;
  bwm_beat_t        stage_d;
  logic             stage_valid_q;
  logic             stage_valid_d;
  logic             fifo_in_ready;
  logic             beat_take;
  logic             stage_push;
  logic [LANES-1:0] beat_we;
  bwm_beat_t        fifo_out;

  // each beat decoded on its own selects, whichever edge it came on
  assign beat_we    = lane_enables(lane_write_select_n);
  assign stage_push = stage_valid_q && fifo_in_ready;
  assign beat_ready = !stage_valid_q || fifo_in_ready;
  assign beat_take  = beat_valid && beat_ready;

  // masked lanes are zeroed so no stale bits can reach the core
  assign stage_d.phase   = beat_phase;
  assign stage_d.lane_we = beat_we;
  assign stage_d.data    = beat_data & lane_mask(beat_we);

  // a beat with every lane masked never occupies the buffer
  assign stage_valid_d = (beat_take && (beat_we != LANES_NONE))
                         ? 1'b1 : (stage_push ? 1'b0 : stage_valid_q);

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      stage_valid_q <= STAGE_VALID_RST;
      stage_q       <= STAGE_RST;
    end else begin
      stage_valid_q <= stage_valid_d;
      if (beat_take) stage_q <= stage_d;
    end
  end

  bwm_fifo #(
    .WIDTH ($bits(bwm_beat_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .reset_n   (reset_n),
    .in_valid  (stage_valid_q),
    .in_ready  (fifo_in_ready),
    .in_data   (stage_q),
    .out_valid (core_wr_valid),
    .out_ready (core_wr_ready),
    .out_data  (fifo_out)
  );

  assign core_wr_phase = fifo_out.phase;
  assign core_lane_we  = fifo_out.lane_we;
  assign core_wr_data  = fifo_out.data;

  // checks
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  chk_all_lanes_on: assert property (
    beat_take && lane_write_select_n == 4'h0
    |=> stage_valid_q && stage_q.lane_we == LANES_ALL && stage_q.data == $past(beat_data))
    else $error("all-low selects did not enable every lane");

  chk_lane0_only: assert property (
    beat_take && lane_write_select_n == 4'he
    |=> stage_q.lane_we == 4'h1 && stage_q.data[35:9] == 27'h0
        && stage_q.data[8:0] == $past(beat_data[8:0]))
    else $error("select 0 alone did not write only lane 0");

  chk_lane1_only: assert property (
    beat_take && lane_write_select_n == 4'hd
    |=> stage_q.lane_we == 4'h2 && stage_q.data[17:9] == $past(beat_data[17:9])
        && stage_q.data[8:0] == 9'h0 && stage_q.data[35:18] == 18'h0)
    else $error("select 1 alone did not write only lane 1");

  chk_lane2_only: assert property (
    beat_take && lane_write_select_n == 4'hb
    |=> stage_q.lane_we == 4'h4 && stage_q.data[26:18] == $past(beat_data[26:18])
        && stage_q.data[17:0] == 18'h0 && stage_q.data[35:27] == 9'h0)
    else $error("select 2 alone did not write only lane 2");

  chk_lane3_only: assert property (
    beat_take && lane_write_select_n == 4'h7
    |=> stage_q.lane_we == 4'h8 && stage_q.data[35:27] == $past(beat_data[35:27])
        && stage_q.data[26:0] == 27'h0)
    else $error("select 3 alone did not write only lane 3");

  chk_masked_beat_dropped: assert property (
    beat_take && lane_write_select_n == 4'hf && (!stage_valid_q || stage_push)
    |=> !stage_valid_q)
    else $error("fully masked beat was forwarded");

  chk_phase_kept: assert property (
    beat_take && lane_write_select_n != 4'hf |=> stage_q.phase == $past(beat_phase))
    else $error("beat phase lost in decode");

  chk_stage_holds: assert property (
    stage_valid_q && !fifo_in_ready |=> stage_valid_q && $stable(stage_q))
    else $error("registered beat changed while stalled");

  chk_polarity: assert property (
    beat_take && lane_write_select_n != 4'hf
    |=> stage_q.lane_we == ~$past(lane_write_select_n))
    else $error("lane enable polarity wrong");

  chk_core_lanes_zero: assert property (
    core_wr_valid |-> (core_wr_data & ~lane_mask(core_lane_we)) == 36'h0
                      && core_lane_we != LANES_NONE)
    else $error("core word carries bits in a masked lane");

  // the core may stall; the head word must not move under it
  chk_core_stands: assert property (
    core_wr_valid && !core_wr_ready
    |=> core_wr_valid && $stable(core_wr_data)
        && $stable(core_lane_we) && $stable(core_wr_phase))
    else $error("core word changed before it was taken");

  chk_stage_to_buffer: assert property (
    stage_valid_q && fifo_in_ready |=> core_wr_valid)
    else $error("registered beat did not enter the buffer");

  chk_lane0_kept: assert property (
    beat_take && !lane_write_select_n[0] |=> stage_q.data[8:0] == $past(beat_data[8:0]))
    else $error("enabled lane 0 not stored");

  chk_lane0_cleared: assert property (
    beat_take && lane_write_select_n[0] |=> stage_q.data[8:0] == 9'h0)
    else $error("masked lane 0 carried data");

  chk_lane1_kept: assert property (
    beat_take && !lane_write_select_n[1] |=> stage_q.data[17:9] == $past(beat_data[17:9]))
    else $error("enabled lane 1 not stored");

  chk_lane1_cleared: assert property (
    beat_take && lane_write_select_n[1] |=> stage_q.data[17:9] == 9'h0)
    else $error("masked lane 1 carried data");

  chk_lane2_kept: assert property (
    beat_take && !lane_write_select_n[2] |=> stage_q.data[26:18] == $past(beat_data[26:18]))
    else $error("enabled lane 2 not stored");

  chk_lane2_cleared: assert property (
    beat_take && lane_write_select_n[2] |=> stage_q.data[26:18] == 9'h0)
    else $error("masked lane 2 carried data");

  chk_lane3_kept: assert property (
    beat_take && !lane_write_select_n[3] |=> stage_q.data[35:27] == $past(beat_data[35:27]))
    else $error("enabled lane 3 not stored");

  chk_lane3_cleared: assert property (
    beat_take && lane_write_select_n[3] |=> stage_q.data[35:27] == 9'h0)
    else $error("masked lane 3 carried data");

  cov_full_word: cover property (beat_take && lane_write_select_n == 4'h0);
  cov_mixed_beats: cover property (
    beat_take && beat_phase == PHASE_TRUE && lane_write_select_n == 4'he
    ##1 beat_take && beat_phase == PHASE_COMP && lane_write_select_n == 4'h7);
  cov_backpressure: cover property (beat_valid && !beat_ready);
  cov_core_write: cover property (core_wr_valid && core_wr_ready);
  cov_masked_beat: cover property (beat_take && lane_write_select_n == 4'hf);
endmodule

// file: design/bwm_fifo.sv
// first-in first-out buffer of flip-flops with valid/ready on both sides
`timescale 1ns/10ps
module bwm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_ptr_q;
  logic [AW-1:0]    rd_ptr_q;
  logic [AW:0]      count_q;
  logic             push;
  logic             pop;
  logic             full;
  logic             empty;

  assign full      = (count_q == (AW+1)'(DEPTH));
  assign empty     = (count_q == '0);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign push      = in_valid && !full;
  assign pop       = out_ready && !empty;
  assign out_data  = mem_q[rd_ptr_q];

  // pointers wrap by hand so depth need not be a power of two
  function automatic logic [AW-1:0] next_ptr(input logic [AW-1:0] p);
    next_ptr = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q  <= '0;
    end else begin
      if (push) wr_ptr_q <= next_ptr(wr_ptr_q);
      if (pop) rd_ptr_q <= next_ptr(rd_ptr_q);
      if (push && !pop) count_q <= count_q + (AW+1)'(1);
      else if (pop && !push) count_q <= count_q - (AW+1)'(1);
    end
  end

  // storage carries no reset; the valid count guards every read
  always_ff @(posedge sys_clk) begin
    if (push) mem_q[wr_ptr_q] <= in_data;
  end
endmodule

// file: dv/bwm_ctl_model.sv
// controller model offering write data beats to the lane decoder
`timescale 1ns/10ps
module bwm_ctl_model
  import bwm_pkg::*;
(
  // clock
  input  wire logic              sys_clk,
  // write beats
  output logic                   beat_valid,
  output logic                   beat_phase,
  output logic      [DATA_W-1:0] beat_data,
  output logic      [LANES-1:0]  lane_write_select_n,
  input  wire logic              beat_ready
);
  initial begin
    beat_valid = 1'b0;
    beat_phase = 1'b0;
    beat_data = 36'h0;
    lane_write_select_n = 4'hf;
  end
  // call just after a rising edge; holds the beat until it is taken
  task automatic send(input logic ph, input logic [LANES-1:0] sel, input logic [DATA_W-1:0] d,
                      output logic taken);
    int n;
    n = 0;
    beat_valid <= 1'b1;
    beat_phase <= ph;
    lane_write_select_n <= sel;
    beat_data <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (beat_ready !== 1'b1 && n < 200);
    taken = beat_ready;
  endtask
  // inverted leftovers so stale values never pass for fresh ones
  task automatic idle();
    beat_valid <= 1'b0;
    beat_data <= ~beat_data;
    lane_write_select_n <= ~lane_write_select_n;
  endtask
endmodule

// file: dv/test_x36_byte_write_mask_decode.sv
// self-checking bench for the lane write select decoder
`timescale 1ns/10ps
module test_x36_byte_write_mask_decode
  import bwm_pkg::*;
;
  logic sys_clk, reset_n, beat_valid, beat_phase, beat_ready;
  logic core_wr_valid, core_wr_ready, core_wr_phase;
  logic [DATA_W-1:0] beat_data, core_wr_data;
  logic [LANES-1:0] sel_n, core_lane_we;
  logic [40:0] exp_q[$];
  logic [40:0] want;
  int mismatches = 0;
  int total_checks = 0;
  bwm_ctl_model ctl (.sys_clk(sys_clk), .beat_valid(beat_valid), .beat_phase(beat_phase),
    .beat_data(beat_data), .lane_write_select_n(sel_n), .beat_ready(beat_ready));
  bwm_lane_decode dut (.sys_clk(sys_clk), .reset_n(reset_n), .beat_valid(beat_valid),
    .beat_phase(beat_phase), .beat_data(beat_data), .lane_write_select_n(sel_n),
    .beat_ready(beat_ready), .core_wr_valid(core_wr_valid), .core_wr_ready(core_wr_ready),
    .core_wr_phase(core_wr_phase), .core_lane_we(core_lane_we), .core_wr_data(core_wr_data));
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  task automatic bad(input string what, input logic [40:0] e, input logic [40:0] s);
    mismatches++;
    $display("unexpected %s expected %h seen %h", what, e, s);
  endtask
  // select n low keeps bits 9n+8:9n of the beat
  function automatic logic [DATA_W-1:0] keep(input logic [LANES-1:0] s);
    logic [DATA_W-1:0] m;
    m = 36'h0;
    for (int n = 0; n < LANES; n++) if (s[n] === 1'b0) m[n*LANE_W +: LANE_W] = 9'h1ff;
    return m;
  endfunction
  task automatic beat(input logic ph, input logic [LANES-1:0] s, input logic [DATA_W-1:0] d);
    logic taken;
    if (s !== 4'hf) exp_q.push_back({ph, ~s, d & keep(s)});
    ctl.send(ph, s, d, taken);
    if (taken !== 1'b1) bad("beat taken", 41'h1, 41'(taken));
  endtask
  always @(posedge sys_clk) begin
    if (reset_n === 1'b1 && core_wr_valid === 1'b1 && core_wr_ready === 1'b1) begin
      total_checks++;
      want = (exp_q.size() > 0) ? exp_q.pop_front() : 41'h0;
      if ({core_wr_phase, core_lane_we, core_wr_data} !== want)
        bad("core word", want, {core_wr_phase, core_lane_we, core_wr_data});
    end
  end
  task automatic drain();
    int n;
    n = 0;
    ctl.idle();
    while (exp_q.size() != 0 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    @(posedge sys_clk);
    #1;
    total_checks++;
    if (exp_q.size() != 0 || core_wr_valid !== 1'b0)
      bad("drained", 41'h0, 41'(exp_q.size()));
    @(posedge sys_clk);
  endtask
  task automatic t_lane_codes();
    logic [LANES-1:0] codes[6] = '{4'h0, 4'he, 4'hd, 4'hb, 4'h7, 4'hf};
    for (int i = 0; i < 6; i++) beat(1'b0, codes[i], 36'h5a5a5a5a5 + i);
    drain();
  endtask
  task automatic t_two_edges();
    logic [LANES-1:0] codes[6] = '{4'he, 4'h7, 4'h0, 4'hf, 4'hd, 4'hb};
    for (int i = 0; i < 6; i++) beat(i[0], codes[i], 36'hc3c3c3c3c ^ i);
    drain();
  endtask
  // reset in mid-run empties stage and buffer; later beats start clean
  task automatic t_reset();
    core_wr_ready <= 1'b0;
    beat(1'b0, 4'h0, 36'h123456789);
    beat(1'b1, 4'h0, 36'hfedcba987);
    ctl.idle();
    reset_n <= 1'b0;
    @(posedge sys_clk);
    #1;
    total_checks++;
    if ({core_wr_valid, beat_ready} !== 2'b01)
      bad("reset outputs", 41'h1, 41'({core_wr_valid, beat_ready}));
    exp_q.delete();
    @(posedge sys_clk);
    reset_n <= 1'b1;
    core_wr_ready <= 1'b1;
    @(posedge sys_clk);
  endtask
  // stalled core: stage plus 32 entries fill, a 34th beat waits for room
  task automatic t_fill();
    core_wr_ready <= 1'b0;
    for (int i = 0; i < 33; i++) beat(1'b1, 4'h0, 36'h100000000 + i);
    fork
      beat(1'b0, 4'h0, 36'h1000000ff);
      begin
        repeat (3) @(posedge sys_clk);
        #1;
        total_checks++;
        if (beat_ready !== 1'b0) bad("ready when full", 41'h0, 41'(beat_ready));
        @(posedge sys_clk);
        core_wr_ready <= 1'b1;
      end
    join
    drain();
  endtask
  task automatic results();
    if (mismatches == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    #20000;
    mismatches++;
    results();
  end
  initial begin
    reset_n = 1'b0;
    core_wr_ready = 1'b1;
    repeat (6) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    t_lane_codes();
    t_two_edges();
    t_reset();
    t_fill();
    results();
  end
endmodule
